// *** bench/front_panel_model.sv ***
// front_panel_model: keys of the front panel as seen by the alarm manager.
// assumes: one clock; key levels change by nba just after a rising edge.
`timescale 1ns/1ps
module front_panel_model (
    input  wire logic clk_i,
    output logic      reset_key_o,
    output logic      mode_key_o
);
    // keys idle released
    initial begin
        reset_key_o = 1'b0;
        mode_key_o  = 1'b0;
    end

    // key held for a given number of clocks, then let go
    task automatic hold_key(input int cycles);
        @(posedge clk_i);
        reset_key_o <= 1'b1;
        repeat (cycles) @(posedge clk_i);
        reset_key_o <= 1'b0;
    endtask : hold_key

    // one press of the mode key is a single clock pulse
    task automatic press_mode();
        @(posedge clk_i);
        mode_key_o <= 1'b1;
        @(posedge clk_i);
        mode_key_o <= 1'b0;
    endtask : press_mode
endmodule : front_panel_model

// *** bench/protector_alarm_manager_tb.sv ***
// protector_alarm_manager_tb: register, run-time, trip and restart tests.
// assumes: alarm_manager with a 4-clock tick; lockout figures are fixed.
`timescale 1ns/1ps
`include "alarm_map.svh"
module protector_alarm_manager_tb;
    import alarm_pkg::*;
    localparam int CPT = 4; // clocks per tick, keeps 15 s at 60000 clocks
    logic       clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    alarm_vec_t detect_i = '0;
    clear_ok_t  clear_ok_i = '0;
    logic [1:0] nv_trip_i = 2'h0;
    logic       comm_reset_i = 1'b0;
    logic       clear_item_sel_i = 1'b0;
    logic       answer_yes_i = 1'b0;
    reg_req_t   req_i = '0;
    logic       reset_key, mode_key, irq_o, trip_o, gen_o, temp_o, br_o;
    logic       disp_value, choice_o, zero_o;
    logic [31:0] rdata_o, rd_val;
    logic [1:0]  nv_trip_o;
    logic [2:0]  disp_code;
    int mismatches = 0;
    int checks = 0;
    int toggles = 0;
    int toggles_at = 0;
    int zero_cnt = 0;
    logic disp_prev = 1'b0;

    always #5 clk_i = ~clk_i;

    front_panel_model front_u (.clk_i(clk_i), .reset_key_o(reset_key),
        .mode_key_o(mode_key));

    alarm_manager #(.CYC_PER_TICK(CPT), .DISP_MS(2)) dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .detect_i(detect_i),
        .clear_ok_i(clear_ok_i), .nv_trip_i(nv_trip_i),
        .reset_key_i(reset_key), .comm_reset_i(comm_reset_i),
        .mode_key_i(mode_key), .clear_item_sel_i(clear_item_sel_i),
        .answer_yes_i(answer_yes_i), .req_i(req_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .trip_status_out_o(trip_o),
        .general_alarm_out_o(gen_o), .overtemp_status_out_o(temp_o),
        .branch_on_o(br_o), .nv_trip_o(nv_trip_o), .disp_code_o(disp_code),
        .disp_value_o(disp_value), .choice_shown_o(choice_o),
        .runtime_zero_o(zero_o));

    // toggle and pulse counters; a level pulse would inflate zero_cnt
    always @(posedge clk_i) begin
        disp_prev <= disp_value;
        if (disp_value !== disp_prev) toggles <= toggles + 1;
        if (zero_o === 1'b1) zero_cnt <= zero_cnt + 1;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req_i <= '0;
    endtask : reg_wr

    // data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_i);
        req_i <= '0;
        #1;
        d = rdata_o;
    endtask : reg_rd

    task automatic pulse_comm();
        @(posedge clk_i);
        comm_reset_i <= 1'b1;
        @(posedge clk_i);
        comm_reset_i <= 1'b0;
    endtask : pulse_comm

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // hang guard sized above the 75000 clocks the tests need
    initial begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        cyc(3);
        // register defaults, unmapped read, enable for run-time event
        reg_rd(`AM_ADDR_ENABLE, rd_val);
        check("enable_rst", rd_val, 32'h0000_0000);
        reg_rd(`AM_ADDR_CONTROL, rd_val);
        check("prot_rst", rd_val, 32'h0000_0001);
        reg_rd(8'h20, rd_val);
        check("unmapped", rd_val, 32'h0000_0000);
        reg_wr(`AM_ADDR_ENABLE, 32'h0000_0020);
        $display("test registers done");

        // run-time alarm, hidden clear at level 2, then clear answered yes
        @(posedge clk_i) detect_i.rt <= 1'b1;
        @(posedge clk_i) detect_i.rt <= 1'b0;
        cyc(3);
        check("rt_gen", gen_o, 1'b0);
        check("rt_branch", br_o, 1'b1);
        check("rt_irq", irq_o, 1'b1);
        check("rt_code", disp_code, 3'h6);
        pulse_comm();
        cyc(3);
        check("rt_no_reset", gen_o, 1'b0);
        reg_wr(`AM_ADDR_CONTROL, 32'h0000_0002);
        clear_item_sel_i <= 1'b1;
        front_u.press_mode();
        cyc(2);
        check("hidden", choice_o, 1'b0);
        reg_wr(`AM_ADDR_CONTROL, 32'h0000_0001);
        front_u.press_mode();
        cyc(2);
        check("choice", choice_o, 1'b1);
        reg_rd(`AM_ADDR_STATE, rd_val);
        check("state_ask", rd_val, 32'h0000_000B);
        @(posedge clk_i) answer_yes_i <= 1'b1;
        front_u.press_mode();
        cyc(3);
        check("zero_pulse", zero_cnt, 32'd1);
        check("rt_cleared", gen_o, 1'b1);
        reg_wr(`AM_ADDR_CLEAR, 32'h0000_0020);
        cyc(2);
        check("irq_clear", irq_o, 1'b0);
        @(posedge clk_i) answer_yes_i <= 1'b0;
        clear_item_sel_i <= 1'b0;
        $display("test runtime done");

        // voltage trip with overvoltage and over-temperature together
        @(posedge clk_i) detect_i <= 7'h45; // ot, ov, tv
        cyc(4);
        @(posedge clk_i) detect_i <= 7'h00;
        clear_ok_i <= 4'h9; // ot_ok and ov_ok
        cyc(3);
        check("trip_out", trip_o, 1'b0);
        check("trip_cut", br_o, 1'b0);
        check("nv_store", nv_trip_o, 2'h1);
        check("ov_gen", gen_o, 1'b0);
        check("ot_out", temp_o, 1'b0);
        check("prio", disp_code, 3'h1);
        reg_rd(`AM_ADDR_ALARM, rd_val);
        check("alarm_flags", rd_val, 32'h0000_0045);
        reg_rd(`AM_ADDR_EVENT, rd_val);
        check("alarm_events", rd_val, 32'h0000_0045);
        check("irq_masked", irq_o, 1'b0);
        reg_rd(`AM_ADDR_STATE, rd_val);
        check("state_cut", rd_val, 32'h0000_0004);
        toggles_at = toggles;
        cyc(40);
        check("alternate", (toggles - toggles_at) >= 4, 1'b1);
        pulse_comm();
        cyc(3);
        check("early_reset", trip_o, 1'b0);
        cyc(24000); // over 5 s of cool temperature
        check("ot_auto", temp_o, 1'b1);
        check("ov_stays", gen_o, 1'b0);
        cyc(37000); // past 15 s lockout, still inside 500 ms settle
        reg_wr(`AM_ADDR_COMMAND, 32'h0000_0001);
        cyc(3);
        check("cmd_trip_reset", trip_o, 1'b1);
        check("cmd_branch", br_o, 1'b1);
        check("ov_settling", gen_o, 1'b0);
        cyc(1400); // settle now complete
        front_u.hold_key(3100 * CPT);
        cyc(3);
        check("trip_reset", trip_o, 1'b1);
        check("branch_back", br_o, 1'b1);
        check("ov_reset", gen_o, 1'b1);
        $display("test trip done");

        // overvoltage alone, then restart with a stored trip
        @(posedge clk_i) detect_i.ov <= 1'b1;
        @(posedge clk_i) detect_i.ov <= 1'b0;
        cyc(3);
        check("ov_branch_on", br_o, 1'b1);
        check("ov_alarm", gen_o, 1'b0);
        @(posedge clk_i) reset_n_i <= 1'b0;
        nv_trip_i <= 2'h1;
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        cyc(4);
        check("trip_kept", trip_o, 1'b0);
        check("cut_kept", br_o, 1'b0);
        check("ov_auto", gen_o, 1'b1);
        $display("test restart done");
        summarize();
    end
endmodule : protector_alarm_manager_tb

// *** verilog/alarm_hold_timer.sv ***
// alarm_hold_timer: counts ticks while a condition holds continuously.
// assumes: tick_i is a one-cycle pulse from the shared prescaler.
`timescale 1ns/1ps
module alarm_hold_timer #(
    parameter int              W     = 16,
    parameter logic [W-1:0]    LIMIT = 16'h0001
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic tick_i,
    input  wire logic run_i,
    output logic      done_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // restart on any break; one extra tick covers the partial first tick
    always_comb begin
        cnt_d = cnt_q;
        if (!run_i) begin
            cnt_d = '0;
        end else if (tick_i && (cnt_q <= LIMIT)) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // done only while the condition still holds
    assign done_o = run_i && (cnt_q > LIMIT);

endmodule : alarm_hold_timer

// *** verilog/alarm_manager.sv ***
// alarm_manager: sticky alarms, status outputs, cutoff, reset qualification,
// display priority and a small register file with interrupt.
// assumes: detection inputs are synchronous levels from measurement logic;
// nonvolatile trip storage outside feeds nv_trip_i back after power-up.
`timescale 1ns/1ps
`include "alarm_map.svh"
module alarm_manager #(
    parameter int CYC_PER_TICK = `AM_TICK_NS / `AM_CLK_PERIOD_NS,
    parameter int DISP_MS      = `AM_DISP_ALT_MS
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    input  wire alarm_pkg::alarm_vec_t detect_i,
    input  wire alarm_pkg::clear_ok_t clear_ok_i,
    input  wire logic [1:0]           nv_trip_i,
    input  wire logic                 reset_key_i,
    input  wire logic                 comm_reset_i,
    input  wire logic                 mode_key_i,
    input  wire logic                 clear_item_sel_i,
    input  wire logic                 answer_yes_i,
    input  wire alarm_pkg::reg_req_t  req_i,
    output logic [31:0]               rdata_o,
    output logic                      irq_o,
    output logic                      trip_status_out_o,
    output logic                      general_alarm_out_o,
    output logic                      overtemp_status_out_o,
    output logic                      branch_on_o,
    output logic [1:0]                nv_trip_o,
    output logic [2:0]                disp_code_o,
    output logic                      disp_value_o,
    output logic                      choice_shown_o,
    output logic                      runtime_zero_o
);
    import alarm_pkg::*;

    localparam int NT = 9;
    localparam logic [15:0] LIM [NT] = '{
        16'(`AM_KEY_HOLD_MS / `AM_TICK_MS), 16'(`AM_LOCKOUT_MS / `AM_TICK_MS),
        16'(`AM_LOCKOUT_MS / `AM_TICK_MS),  16'(`AM_SETTLE_MS / `AM_TICK_MS),
        16'(`AM_LOCKOUT_MS / `AM_TICK_MS),  16'(`AM_SETTLE_MS / `AM_TICK_MS),
        16'(`AM_LOCKOUT_MS / `AM_TICK_MS),  16'(`AM_SETTLE_MS / `AM_TICK_MS),
        16'(`AM_OTEMP_MS / `AM_TICK_MS)};

    alarm_vec_t  flags_q, flags_d;
    logic [6:0]  ev_q, ev_d, en_q, en_d;
    logic [1:0]  prot_q, prot_d;
    rtc_state_t  rtc_q, rtc_d;
    logic        init_q, key_done_q;
    logic [31:0] pre_q, pre_d;
    logic [31:0] alt_q, alt_d;
    logic        tick;
    logic [NT-1:0] run, done;
    logic        reset_req, trip_clr, rt_zero;
    logic [31:0] rdata_d;
    logic [2:0]  code_d;
    logic        dval_d, choice_d;

    // shared millisecond prescaler
    always_comb begin
        tick  = (pre_q == 32'(CYC_PER_TICK - 1));
        pre_d = tick ? 32'h0 : pre_q + 32'h1;
        alt_d = alt_q;
        dval_d = disp_value_o;
        if (flags_q == '0) begin
            alt_d  = 32'h0;
            dval_d = 1'b0;
        end else if (tick) begin
            alt_d = (alt_q == 32'(DISP_MS - 1)) ? 32'h0 : alt_q + 32'h1;
            if (alt_q == 32'(DISP_MS - 1)) begin
                dval_d = ~disp_value_o;
            end
        end
    end

    // qualifying conditions; each timer restarts when its run drops
    always_comb begin
        run[0] = reset_key_i;
        run[1] = flags_q.tv | flags_q.tc;
        run[2] = flags_q.ov;
        run[3] = flags_q.ov & done[2] & clear_ok_i.ov_ok;
        run[4] = flags_q.uv;
        run[5] = flags_q.uv & done[4] & clear_ok_i.uv_ok;
        run[6] = flags_q.oc;
        run[7] = flags_q.oc & done[6] & clear_ok_i.oc_ok;
        run[8] = flags_q.ot & clear_ok_i.ot_ok & ~detect_i.ot;
    end

    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : g_tmr
            alarm_hold_timer #(.W(16), .LIMIT(LIM[g])) u_tmr (
                .clk_i     (clk_i),
                .reset_n_i (reset_n_i),
                .tick_i    (tick),
                .run_i     (run[g]),
                .done_o    (done[g])
            );
        end
    endgenerate

    // reset request: key hold edge, remote line, or command register
    assign reset_req = (done[0] & ~key_done_q) | comm_reset_i
        | (req_i.wr && req_i.addr == `AM_ADDR_COMMAND
           && req_i.wdata[`AM_CMD_RESET_BIT]);
    assign trip_clr = reset_req & done[1]
        & ~detect_i.tv & ~detect_i.tc;

    // run-time clear dialogue
    always_comb begin
        rtc_d   = rtc_q;
        rt_zero = 1'b0;
        case (rtc_q)
            RTC_IDLE: begin
                if (clear_item_sel_i && mode_key_i
                    && prot_q != `AM_PROT_HIDDEN) begin
                    rtc_d = RTC_ASK;
                end
            end
            RTC_ASK: begin
                if (prot_q == `AM_PROT_HIDDEN || !clear_item_sel_i) begin
                    rtc_d = RTC_IDLE;
                end else if (mode_key_i) begin
                    rtc_d   = RTC_IDLE;
                    rt_zero = answer_yes_i;
                end
            end
            default: rtc_d = RTC_IDLE;
        endcase
        choice_d = (rtc_d == RTC_ASK);
    end

    // sticky alarm flags; a new detection wins over any clear
    always_comb begin
        flags_d    = flags_q;
        flags_d.tv = detect_i.tv | (flags_q.tv & ~trip_clr);
        flags_d.tc = detect_i.tc | (flags_q.tc & ~trip_clr);
        if (!init_q) begin
            flags_d.tv = flags_d.tv | nv_trip_i[0];
            flags_d.tc = flags_d.tc | nv_trip_i[1];
        end
        // not restored at power-up, so they return only if still present
        flags_d.ov = detect_i.ov | (flags_q.ov & ~(reset_req & done[3]));
        flags_d.uv = detect_i.uv | (flags_q.uv & ~(reset_req & done[5]));
        flags_d.oc = detect_i.oc | (flags_q.oc & ~(reset_req & done[7]));
        flags_d.rt = detect_i.rt | (flags_q.rt & ~rt_zero);
        flags_d.ot = detect_i.ot | (flags_q.ot & ~done[8]);
    end

    // highest-priority active alarm, 1 = A10 .. 7 = A30
    always_comb begin
        code_d = 3'h0;
        for (int i = `AM_NUM_ALARMS - 1; i >= 0; i--) begin
            if (flags_q[i]) begin
                code_d = 3'(i + 1);
            end
        end
    end

    // register file; rising alarm sets event, set wins over clear
    always_comb begin
        ev_d    = ev_q | (flags_d & ~flags_q);
        en_d    = en_q;
        prot_d  = prot_q;
        rdata_d = 32'h0;
        if (req_i.wr) begin
            case (req_i.addr)
                `AM_ADDR_CLEAR:
                    ev_d = (ev_q & ~req_i.wdata[6:0]) | (flags_d & ~flags_q);
                `AM_ADDR_ENABLE:  en_d   = req_i.wdata[6:0];
                `AM_ADDR_CONTROL: prot_d = req_i.wdata[`AM_PROT_LSB +: 2];
                default: ;
            endcase
        end
        if (req_i.rd) begin
            case (req_i.addr)
                `AM_ADDR_ALARM:   rdata_d = {25'h0, flags_q};
                `AM_ADDR_EVENT:   rdata_d = {25'h0, ev_q};
                `AM_ADDR_ENABLE:  rdata_d = {25'h0, en_q};
                `AM_ADDR_CONTROL: rdata_d = {30'h0, prot_q};
                `AM_ADDR_STATE:   rdata_d = {28'h0, rtc_q, branch_on_o,
                                             choice_shown_o};
                default:          rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_q    <= '0;
            ev_q       <= 7'h00;
            en_q       <= 7'h00;
            prot_q     <= `AM_PROT_RST;
            rtc_q      <= RTC_IDLE;
            init_q     <= 1'b0;
            key_done_q <= 1'b0;
            pre_q      <= 32'h0;
            alt_q      <= 32'h0;
            rdata_o    <= 32'h0;
            irq_o      <= 1'b0;
            trip_status_out_o     <= 1'b1;
            general_alarm_out_o   <= 1'b1;
            overtemp_status_out_o <= 1'b1;
            branch_on_o    <= 1'b0; // held off until stored trip is known
            nv_trip_o      <= 2'h0;
            disp_code_o    <= 3'h0;
            disp_value_o   <= 1'b0;
            choice_shown_o <= 1'b0;
            runtime_zero_o <= 1'b0;
        end else begin
            flags_q    <= flags_d;
            ev_q       <= ev_d;
            en_q       <= en_d;
            prot_q     <= prot_d;
            rtc_q      <= rtc_d;
            init_q     <= 1'b1;
            key_done_q <= done[0];
            pre_q      <= pre_d;
            alt_q      <= alt_d;
            rdata_o    <= rdata_d;
            irq_o      <= |(ev_d & en_d);
            trip_status_out_o   <= ~(flags_q.tv | flags_q.tc);
            general_alarm_out_o <= ~(flags_q.ov | flags_q.uv
                                     | flags_q.oc | flags_q.rt);
            overtemp_status_out_o <= ~flags_q.ot;
            branch_on_o    <= init_q & ~(flags_q.tv | flags_q.tc);
            nv_trip_o      <= {flags_q.tc, flags_q.tv};
            disp_code_o    <= code_d;
            disp_value_o   <= dval_d;
            choice_shown_o <= choice_d;
            runtime_zero_o <= rt_zero;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_yes_press;
        (rtc_q == RTC_ASK) && mode_key_i && answer_yes_i && clear_item_sel_i
            && prot_q != `AM_PROT_HIDDEN;
    endsequence
    sequence s_cool_done;
        flags_q.ot && done[8] && !detect_i.ot;
    endsequence

    chk_trip_cuts_branch: assert property (
        (flags_q.tv || flags_q.tc) |=> !branch_on_o && !trip_status_out_o)
        else $error("trip did not cut branch power");
    chk_key_hold_len: assert property (
        $rose(done[0]) |-> $past(reset_key_i, 1) && $past(reset_key_i, 8))
        else $error("key reset accepted without hold");
    chk_trip_lockout: assert property (
        $fell(flags_q.tv | flags_q.tc) |-> $past(done[1]))
        else $error("trip cleared inside lockout");
    chk_trip_restore: assert property (
        !init_q |=> (({flags_q.tc, flags_q.tv} & $past(nv_trip_i))
                     == $past(nv_trip_i)))
        else $error("stored trip lost at power-up");
    chk_alarm_keeps_on: assert property (
        (flags_q.ov || flags_q.uv || flags_q.oc) && !flags_q.tv && !flags_q.tc
        && init_q |=> !general_alarm_out_o && branch_on_o)
        else $error("alarm output or branch state wrong");
    chk_ov_settle: assert property (
        $fell(flags_q.ov) |-> $past(done[3]) && $past(done[2]))
        else $error("overvoltage cleared without settle");
    chk_uv_settle: assert property (
        $fell(flags_q.uv) |-> $past(done[5]) && $past(done[4]))
        else $error("undervoltage cleared without settle");
    chk_oc_settle: assert property (
        $fell(flags_q.oc) |-> $past(done[7]) && $past(done[6]))
        else $error("overcurrent cleared without settle");
    chk_rt_only_clear: assert property (
        $fell(flags_q.rt) |-> $past(rt_zero))
        else $error("run-time alarm cleared without clear operation");
    chk_rt_zero_yes: assert property (
        s_yes_press |=> runtime_zero_o ##1 !runtime_zero_o)
        else $error("yes press did not zero run time");
    chk_prot_hides: assert property (
        prot_q == `AM_PROT_HIDDEN |=> rtc_q == RTC_IDLE && !rt_zero)
        else $error("clear item reachable at level 2");
    chk_otemp_auto: assert property (
        s_cool_done |=> !flags_q.ot ##1 overtemp_status_out_o)
        else $error("over-temperature did not self-clear");
    chk_disp_prio: assert property (
        flags_q.tv |=> disp_code_o == 3'h1)
        else $error("display priority wrong");

endmodule : alarm_manager

// *** verilog/alarm_map.svh ***
// alarm_map.svh: register offsets, field positions, reset values and timer
// figures for the protector alarm manager.
// assumes: included by bare name by the package user; definitions only.
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH

// register byte addresses
`define AM_ADDR_ALARM    8'h00
`define AM_ADDR_EVENT    8'h04
`define AM_ADDR_CLEAR    8'h08
`define AM_ADDR_ENABLE   8'h0C
`define AM_ADDR_CONTROL  8'h10
`define AM_ADDR_COMMAND  8'h14
`define AM_ADDR_STATE    8'h18

// field positions and alarm count
`define AM_CMD_RESET_BIT 0
`define AM_PROT_LSB      0
`define AM_NUM_ALARMS    7

// protection levels: reset value and hidden level
`define AM_PROT_RST      2'h1
`define AM_PROT_HIDDEN   2'h2

// clock and tick
`define AM_CLK_PERIOD_NS 10
`define AM_TICK_NS       1000000
`define AM_TICK_MS       1

// timer figures in milliseconds
`define AM_KEY_HOLD_MS   3000
`define AM_LOCKOUT_MS    15000
`define AM_SETTLE_MS     500
`define AM_OTEMP_MS      5000
`define AM_DISP_ALT_MS   1000

`endif

// *** verilog/alarm_pkg.sv ***
// alarm_pkg: types shared by the alarm manager and its testbench.
// assumes: alarm_map.svh holds every number; this file holds types only.
package alarm_pkg;

    // one flag per alarm, lowest bit is the highest priority
    typedef struct packed {
        logic ot;      // over-temperature
        logic rt;      // run-time limit
        logic oc;      // overcurrent
        logic uv;      // undervoltage
        logic ov;      // overvoltage
        logic tc;      // abnormal current trip
        logic tv;      // abnormal voltage trip
    } alarm_vec_t;

    // conditions that allow an alarm to go away
    typedef struct packed {
        logic ot_ok;   // temperature below threshold minus 3 C
        logic oc_ok;   // current below threshold
        logic uv_ok;   // voltage above threshold plus 0.3 V
        logic ov_ok;   // voltage below threshold minus 0.3 V
    } clear_ok_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        RTC_IDLE = 2'b01,
        RTC_ASK  = 2'b10
    } rtc_state_t;

endpackage : alarm_pkg
